// File: common/dual_conv_pkg.sv
// Shared constants and types for the dual converter output path and its capture end
// Overview of operation
// - Each channel has its own sample clock
// - Sample taken on rising channel clock edge
// - Result appears seven clock cycles after capture
// - Output changes after edge, captured next edge
// - Format pin low offset binary, high twos
// - Swap select high routes A-A, B-B
// - Swap select low crosses channels between ports
// - Select tied to clock gives two words/cycle
// - Capture takes a word each select edge
// - Multiplexed mode keeps both channels powered up
// - Disable pin high turns port off
// - One power-down pin idles only its channel
// - Both power-downs also stop shared references
// - Discard data about 5 ms after full wake
// - Single-channel wake within several clock cycles
// - Stabiliser enable regenerates 50 percent internal clock
// - Wait 2 to 3 us after rate change
// - Stop clock of idle channel with stabiliser
// - Keep sample rate at least 1 MSPS
package dual_conv_pkg;
  localparam int DATA_W = 14;
  localparam int PIPE_DEPTH = 7;
  localparam logic [13:0] MSB_FLIP = 14'h2000;
  localparam logic [13:0] DATA_RESET = 14'h0000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int REF_WAKE_MS = 5;
  localparam int REF_WAKE_CYC = (REF_WAKE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int DLL_LOCK_US = 3;
  localparam int DLL_LOCK_CYC = (DLL_LOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHAN_WAKE_CYC = 4;
  localparam int MIN_RATE_KSPS = 1000;
  localparam int MAX_DIV = (1000000 / MIN_RATE_KSPS) / CLK_PERIOD_NS;
  localparam logic [7:0] DIV_RESET = 8'h01;
  typedef enum logic [2:0] {
    CAP_IDLE = 3'b001,
    CAP_SETTLE = 3'b010,
    CAP_RUN = 3'b100
  } cap_state_type;
endpackage : dual_conv_pkg

// File: common/dual_conv_if.sv
// Pin-level link between the converter end and the capture end
`timescale 1ns/1ps
`default_nettype none
interface dual_conv_if;
  logic clk_a_en;
  logic clk_b_en;
  logic port_swap_select;
  logic output_format_select;
  logic duty_stabiliser_enable;
  logic chan_a_powerdown;
  logic chan_b_powerdown;
  logic port_a_output_disable_n;
  logic port_b_output_disable_n;
  logic [13:0] port_a_data;
  logic [13:0] port_b_data;
  logic port_a_oe;
  logic port_b_oe;
  modport converter (
    input clk_a_en, clk_b_en, port_swap_select, output_format_select, duty_stabiliser_enable,
    input chan_a_powerdown, chan_b_powerdown, port_a_output_disable_n, port_b_output_disable_n,
    output port_a_data, port_b_data, port_a_oe, port_b_oe
  );
  modport capture (
    output clk_a_en, clk_b_en, port_swap_select, output_format_select, duty_stabiliser_enable,
    output chan_a_powerdown, chan_b_powerdown, port_a_output_disable_n, port_b_output_disable_n,
    input port_a_data, port_b_data, port_a_oe, port_b_oe
  );
endinterface : dual_conv_if
`default_nettype wire

// File: rtl/conv_channel.sv
// One conversion channel: sampling, seven-deep pipeline, coding, standby
`timescale 1ns/1ps
`default_nettype none
module conv_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sample clock edge and controls
  input wire logic sample_en,
  input wire logic powerdown,
  input wire logic refs_up,
  input wire logic twos_comp,
  // Analog stand-in
  input wire logic [13:0] sample_in,
  // Result
  output logic [13:0] result,
  output logic running
);
  logic [13:0] pipe_r [dual_conv_pkg::PIPE_DEPTH];
  logic [2:0] wake_r;

  // Short wake after a single-channel standby, references still up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_r <= 3'h0;
    end else if (powerdown || !refs_up) begin
      wake_r <= 3'h0;
    end else if (sample_en && wake_r != 3'(dual_conv_pkg::CHAN_WAKE_CYC)) begin
      wake_r <= wake_r + 3'h1;
    end
  end
  assign running = (wake_r == 3'(dual_conv_pkg::CHAN_WAKE_CYC));

  // Pipeline steps on each rising sample edge while the channel is running
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < dual_conv_pkg::PIPE_DEPTH; i++) begin
        pipe_r[i] <= dual_conv_pkg::DATA_RESET;
      end
    end else if (sample_en && running) begin
      pipe_r[0] <= twos_comp ? (sample_in ^ dual_conv_pkg::MSB_FLIP) : sample_in;
      for (int i = 1; i < dual_conv_pkg::PIPE_DEPTH; i++) begin
        pipe_r[i] <= pipe_r[i-1];
      end
    end
  end
  assign result = pipe_r[dual_conv_pkg::PIPE_DEPTH-1];
endmodule : conv_channel
`default_nettype wire

// File: rtl/conv_device.sv
// Converter end: two channels, port routing, output disable, standby
`timescale 1ns/1ps
`default_nettype none
module conv_device (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Link
  dual_conv_if.converter LINK,
  // Sample values from the analog front end
  input wire logic [13:0] SAMPLE_A,
  input wire logic [13:0] SAMPLE_B,
  // Status
  output logic REFS_UP,
  output logic INT_CLK_A,
  output logic INT_CLK_B
);
  logic [13:0] res_a;
  logic [13:0] res_b;
  logic refs_r;
  logic [7:0] cnt_a_r;
  logic [7:0] cnt_b_r;
  logic [7:0] per_a_r;
  logic [7:0] per_b_r;
  logic [13:0] pa_r;
  logic [13:0] pb_r;
  logic oea_r;
  logic oeb_r;
  logic ph_a_r;
  logic ph_b_r;

  // Each channel steps on its own clock enable
  conv_channel u_chan_a (
    .clk(CORE_CLK), .rst(RST), .sample_en(LINK.clk_a_en),
    .powerdown(LINK.chan_a_powerdown), .refs_up(refs_r),
    .twos_comp(LINK.output_format_select), .sample_in(SAMPLE_A),
    .result(res_a), .running()
  );
  conv_channel u_chan_b (
    .clk(CORE_CLK), .rst(RST), .sample_en(LINK.clk_b_en),
    .powerdown(LINK.chan_b_powerdown), .refs_up(refs_r),
    .twos_comp(LINK.output_format_select), .sample_in(SAMPLE_B),
    .result(res_b), .running()
  );

  // Shared references off only when both channels are down
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      refs_r <= 1'b0;
    end else begin
      refs_r <= !(LINK.chan_a_powerdown && LINK.chan_b_powerdown);
    end
  end

  // Sample period in core cycles; count saturates while a channel clock is stopped
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cnt_a_r <= 8'h00;
      cnt_b_r <= 8'h00;
      per_a_r <= 8'h00;
      per_b_r <= 8'h00;
    end else begin
      cnt_a_r <= LINK.clk_a_en ? 8'h00 : ((cnt_a_r == 8'hff) ? cnt_a_r : cnt_a_r + 8'h01);
      cnt_b_r <= LINK.clk_b_en ? 8'h00 : ((cnt_b_r == 8'hff) ? cnt_b_r : cnt_b_r + 8'h01);
      if (LINK.clk_a_en) begin
        per_a_r <= cnt_a_r + 8'h01;
      end
      if (LINK.clk_b_en) begin
        per_b_r <= cnt_b_r + 8'h01;
      end
    end
  end

  // Stabiliser: rise on the sample edge, fall at half the last period; raw edge pulse when off
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ph_a_r <= 1'b0;
      ph_b_r <= 1'b0;
    end else if (LINK.duty_stabiliser_enable) begin
      ph_a_r <= LINK.clk_a_en || (ph_a_r && ({1'b0, cnt_a_r} + 9'h001 < {2'b00, per_a_r[7:1]}));
      ph_b_r <= LINK.clk_b_en || (ph_b_r && ({1'b0, cnt_b_r} + 9'h001 < {2'b00, per_b_r[7:1]}));
    end else begin
      ph_a_r <= LINK.clk_a_en;
      ph_b_r <= LINK.clk_b_en;
    end
  end
  assign INT_CLK_A = ph_a_r;
  assign INT_CLK_B = ph_b_r;
  assign REFS_UP = refs_r;

  // Registered ports: select sampled, then words routed; changes only after the edge
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pa_r <= dual_conv_pkg::DATA_RESET;
      pb_r <= dual_conv_pkg::DATA_RESET;
    end else begin
      if (LINK.port_swap_select) begin
        pa_r <= res_a;
        pb_r <= res_b;
      end else begin
        pa_r <= res_b;
        pb_r <= res_a;
      end
    end
  end

  // Port drive enable: off while its disable pin is high
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      oea_r <= 1'b0;
      oeb_r <= 1'b0;
    end else begin
      oea_r <= !LINK.port_a_output_disable_n;
      oeb_r <= !LINK.port_b_output_disable_n;
    end
  end

  // Words launched after the edge, stable for capture on the next one
  assign LINK.port_a_data = pa_r;
  assign LINK.port_b_data = pb_r;
  assign LINK.port_a_oe = oea_r;
  assign LINK.port_b_oe = oeb_r;
endmodule : conv_device
`default_nettype wire

// File: rtl/capture_host.sv
// Capture end: makes sample clocks, drives control pins, takes the output words
`timescale 1ns/1ps
`default_nettype none
module capture_host #(
  parameter int REF_WAKE_CYCLES = dual_conv_pkg::REF_WAKE_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Link
  dual_conv_if.capture LINK,
  // User controls
  input wire logic [7:0] CLK_DIV,
  input wire logic MUX_MODE,
  input wire logic MUX_PORT_B,
  input wire logic TWOS_COMP,
  input wire logic STAB_EN,
  input wire logic PDWN_REQ_A,
  input wire logic PDWN_REQ_B,
  // Captured words
  output logic [13:0] WORD_DATA,
  output logic WORD_CHAN_B,
  output logic WORD_VALID,
  input wire logic WORD_READY,
  output logic BUSY
);
  logic [7:0] div_r;
  logic [7:0] div_cnt_r;
  logic edge_r;
  logic sel_r;
  logic sel_d_r;
  logic pd_a_r;
  logic pd_b_r;
  logic [2:0] disc_r;
  logic [22:0] wait_r;
  logic was_full_r;
  dual_conv_pkg::cap_state_type st_r;
  logic [13:0] buf_d [2];
  logic buf_c [2];
  logic [1:0] cnt_r;
  logic wp_r;
  logic rp_r;
  logic in_v;
  logic [13:0] in_d;
  logic in_c;
  logic in_rdy;
  logic busy_r;

  // Divider: one-cycle sample edge; rate floor keeps 1 MSPS or faster
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      div_r <= dual_conv_pkg::DIV_RESET;
      div_cnt_r <= 8'h00;
      edge_r <= 1'b0;
    end else begin
      div_r <= (CLK_DIV > 8'(dual_conv_pkg::MAX_DIV)) ? 8'(dual_conv_pkg::MAX_DIV) :
               ((CLK_DIV < 8'h02) ? 8'h02 : CLK_DIV);
      edge_r <= 1'b0;
      if (div_cnt_r >= div_r - 8'h01) begin
        div_cnt_r <= 8'h00;
        edge_r <= 1'b1;
      end else begin
        div_cnt_r <= div_cnt_r + 8'h01;
      end
    end
  end

  // Select high for the first half of the period, low for the second
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sel_r <= 1'b1;
    end else if (MUX_MODE) begin
      sel_r <= (div_cnt_r < (div_r >> 1));
    end else begin
      sel_r <= 1'b1;
    end
  end

  // Select as the converter latched it; port words lag the select pin by one cycle
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sel_d_r <= 1'b1;
    end else begin
      sel_d_r <= sel_r;
    end
  end

  // Power-down pins forced low in multiplexed mode
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pd_a_r <= 1'b0;
      pd_b_r <= 1'b0;
    end else begin
      pd_a_r <= PDWN_REQ_A && !MUX_MODE;
      pd_b_r <= PDWN_REQ_B && !MUX_MODE;
    end
  end

  // Stopped clock for a powered-down channel when stabiliser is on
  assign LINK.clk_a_en = edge_r && !(STAB_EN && pd_a_r);
  assign LINK.clk_b_en = edge_r && !(STAB_EN && pd_b_r);
  assign LINK.port_swap_select = sel_r;
  assign LINK.output_format_select = TWOS_COMP;
  assign LINK.duty_stabiliser_enable = STAB_EN;
  assign LINK.chan_a_powerdown = pd_a_r;
  assign LINK.chan_b_powerdown = pd_b_r;
  // In multiplexed mode the unused port is disabled to save power and noise
  assign LINK.port_a_output_disable_n = MUX_MODE && MUX_PORT_B;
  assign LINK.port_b_output_disable_n = MUX_MODE && !MUX_PORT_B;

  // Validity tracker: wait after full wake or a rate change under the stabiliser, then drop words for seven sample edges
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_r <= dual_conv_pkg::CAP_IDLE;
      wait_r <= 23'h00_0000;
      disc_r <= 3'h0;
      was_full_r <= 1'b0;
    end else begin
      was_full_r <= pd_a_r && pd_b_r;
      unique case (st_r)
        dual_conv_pkg::CAP_IDLE: begin
          if (!(pd_a_r && pd_b_r)) begin
            st_r <= dual_conv_pkg::CAP_SETTLE;
            wait_r <= was_full_r ? 23'(REF_WAKE_CYCLES) : 23'(dual_conv_pkg::DLL_LOCK_CYC);
          end
        end
        dual_conv_pkg::CAP_SETTLE: begin
          if (wait_r != 23'h00_0000) begin
            wait_r <= wait_r - 23'h00_0001;
          end else begin
            st_r <= dual_conv_pkg::CAP_RUN;
            disc_r <= 3'(dual_conv_pkg::PIPE_DEPTH);
          end
        end
        dual_conv_pkg::CAP_RUN: begin
          if (pd_a_r && pd_b_r) begin
            st_r <= dual_conv_pkg::CAP_IDLE;
          end else if (div_r != ((CLK_DIV > 8'(dual_conv_pkg::MAX_DIV)) ? 8'(dual_conv_pkg::MAX_DIV) :
                                 ((CLK_DIV < 8'h02) ? 8'h02 : CLK_DIV)) && STAB_EN) begin
            st_r <= dual_conv_pkg::CAP_SETTLE;
            wait_r <= 23'(dual_conv_pkg::DLL_LOCK_CYC);
          end else if (edge_r && disc_r != 3'h0) begin
            disc_r <= disc_r - 3'h1;
          end
        end
      endcase
    end
  end

  // Take a word on each edge; two per period in multiplexed mode, one cycle after each half starts
  always_comb begin
    in_d = MUX_PORT_B ? LINK.port_b_data : LINK.port_a_data;
    in_c = MUX_MODE ? (sel_d_r == MUX_PORT_B) : MUX_PORT_B;
    in_v = (st_r == dual_conv_pkg::CAP_RUN) && disc_r == 3'h0 &&
           (MUX_MODE ? (div_cnt_r == 8'h01 || div_cnt_r == (div_r >> 1) + 8'h01) : edge_r);
  end
  assign in_rdy = (cnt_r != 2'h2);

  // Two-entry buffer; words arriving while it is full are dropped
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cnt_r <= 2'h0;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      buf_d[0] <= dual_conv_pkg::DATA_RESET;
      buf_d[1] <= dual_conv_pkg::DATA_RESET;
      buf_c[0] <= 1'b0;
      buf_c[1] <= 1'b0;
    end else begin
      if (in_v && in_rdy) begin
        buf_d[wp_r] <= in_d;
        buf_c[wp_r] <= in_c;
        wp_r <= ~wp_r;
      end
      if (cnt_r != 2'h0 && WORD_READY) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + 2'((in_v && in_rdy) ? 1 : 0) - 2'((cnt_r != 2'h0 && WORD_READY) ? 1 : 0);
    end
  end

  // Registered busy flag; valid, word and channel come straight from the buffer head
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      busy_r <= 1'b1;
    end else begin
      busy_r <= (st_r != dual_conv_pkg::CAP_RUN) || (disc_r != 3'h0);
    end
  end
  assign WORD_VALID = (cnt_r != 2'h0);
  assign WORD_DATA = buf_d[rp_r];
  assign WORD_CHAN_B = buf_c[rp_r];
  assign BUSY = busy_r;
endmodule : capture_host
`default_nettype wire

// File: sim/dual_conv_chk.sv
// Checker on the link between the converter end and the capture end
`timescale 1ns/1ps
`default_nettype none
module dual_conv_chk (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Link signals
  input wire logic clk_a_en,
  input wire logic clk_b_en,
  input wire logic port_swap_select,
  input wire logic duty_stabiliser_enable,
  input wire logic chan_a_powerdown,
  input wire logic chan_b_powerdown,
  input wire logic port_a_output_disable_n,
  input wire logic port_b_output_disable_n,
  input wire logic [13:0] port_a_data,
  input wire logic port_a_oe,
  input wire logic port_b_oe
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // Ports leave reset quiet: drive off, port A data zero
  a_reset_quiet_ports: assert property ($fell(RST) |-> !port_a_oe && !port_b_oe && port_a_data == 14'h0000)
    else $error("ports not quiet after reset");
  // Sample edges at least two core cycles apart
  a_clk_a_spacing: assert property (clk_a_en |=> !clk_a_en)
    else $error("channel A sample edges too close");
  a_clk_b_spacing: assert property (clk_b_en |=> !clk_b_en)
    else $error("channel B sample edges too close");
  // A disabled port stops driving
  a_port_a_off: assert property (port_a_output_disable_n [*2] |-> !port_a_oe)
    else $error("port A drives while disabled");
  a_port_b_off: assert property (port_b_output_disable_n [*2] |-> !port_b_oe)
    else $error("port B drives while disabled");
  // Toggling select only with both channels awake
  a_mux_powered: assert property ($changed(port_swap_select) |-> !chan_a_powerdown && !chan_b_powerdown)
    else $error("select toggles with a channel in standby");
  // Idle channel clock stopped while stabiliser runs, else the live channel suffers
  a_stab_stop_a: assert property ((duty_stabiliser_enable && chan_a_powerdown) [*3] |-> !clk_a_en)
    else $error("channel A clocked in standby");
  a_stab_stop_b: assert property ((duty_stabiliser_enable && chan_b_powerdown) [*3] |-> !clk_b_en)
    else $error("channel B clocked in standby");
  // Main scenarios
  c_mux: cover property ($changed(port_swap_select));
  c_full_standby: cover property (chan_a_powerdown && chan_b_powerdown);
  c_stab_idle: cover property (duty_stabiliser_enable && chan_a_powerdown);
endmodule : dual_conv_chk
`default_nettype wire

// File: sim/dual_adc_output_and_power_control_bench.sv
// Bench joining both ends and checking captured words and link pins
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("wrong value at %0t: %h %h", $time, g, e); end end
module dual_adc_output_and_power_control_bench;
  // Wake count shortened so full standby exits quickly
  localparam int WAKE = 50;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] sample_a = 14'h1234;
  logic [13:0] sample_b = 14'h2abc;
  logic [7:0] clk_div = 8'h04;
  logic mux_mode = 1'b0;
  logic mux_port_b = 1'b0;
  logic twos = 1'b0;
  logic stab_en = 1'b0;
  logic pd_req_a = 1'b0;
  logic pd_req_b = 1'b0;
  logic word_ready = 1'b1;
  logic [13:0] word_data;
  logic [13:0] held;
  logic word_chan_b;
  logic word_valid;
  logic busy;
  logic refs_up;
  logic int_clk_a;
  logic int_clk_b;
  int errors = 0;
  int cmp_count = 0;
  dual_conv_if link ();
  conv_device u_conv_device (.CORE_CLK(core_clk), .RST(rst), .LINK(link), .SAMPLE_A(sample_a),
    .SAMPLE_B(sample_b), .REFS_UP(refs_up), .INT_CLK_A(int_clk_a), .INT_CLK_B(int_clk_b));
  capture_host #(.REF_WAKE_CYCLES(WAKE)) u_capture_host (.CORE_CLK(core_clk), .RST(rst), .LINK(link),
    .CLK_DIV(clk_div), .MUX_MODE(mux_mode), .MUX_PORT_B(mux_port_b), .TWOS_COMP(twos), .STAB_EN(stab_en),
    .PDWN_REQ_A(pd_req_a), .PDWN_REQ_B(pd_req_b), .WORD_DATA(word_data), .WORD_CHAN_B(word_chan_b),
    .WORD_VALID(word_valid), .WORD_READY(word_ready), .BUSY(busy));
  dual_conv_chk u_dual_conv_chk (.CORE_CLK(core_clk), .RST(rst), .clk_a_en(link.clk_a_en),
    .clk_b_en(link.clk_b_en), .port_swap_select(link.port_swap_select),
    .duty_stabiliser_enable(link.duty_stabiliser_enable), .chan_a_powerdown(link.chan_a_powerdown),
    .chan_b_powerdown(link.chan_b_powerdown), .port_a_output_disable_n(link.port_a_output_disable_n),
    .port_b_output_disable_n(link.port_b_output_disable_n), .port_a_data(link.port_a_data),
    .port_a_oe(link.port_a_oe), .port_b_oe(link.port_b_oe));
  // Core clock, 25 ns period
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  // Verdict and end of run
  task automatic end_of_test();
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  // Bounded wait for trusted output, then time for fresh words to arrive
  task automatic settle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    `CHECK(busy, 1'b0)
    repeat (60) @(negedge core_clk);
  endtask : settle
  // Takes the next word; ready is high so the following edge pops it
  task automatic take_word(output logic [13:0] d, output logic b);
    int n;
    n = 0;
    while (word_valid !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    `CHECK(word_valid, 1'b1)
    d = word_data;
    b = word_chan_b;
    @(negedge core_clk);
  endtask : take_word
  // High cycles of both internal clocks over sixty core cycles, a whole number of periods
  task automatic duty(input int exp);
    int ha;
    int hb;
    ha = 0;
    hb = 0;
    repeat (60) begin
      @(negedge core_clk);
      if (int_clk_a === 1'b1) ha++;
      if (int_clk_b === 1'b1) hb++;
    end
    `CHECK(ha, exp)
    `CHECK(hb, exp)
  endtask : duty
  // Checks n words against coding; alt demands channels interleave
  task automatic words(input int n, input logic alt);
    logic [13:0] d;
    logic b;
    logic prev;
    prev = 1'b0;
    for (int i = 0; i < n; i++) begin
      take_word(d, b);
      `CHECK(d, (b ? sample_b : sample_a) ^ (twos ? dual_conv_pkg::MSB_FLIP : 14'h0000))
      if (alt && i > 0) `CHECK(b, ~prev)
      prev = b;
    end
  endtask : words
  // Main sequence, inputs changed on falling edges
  initial begin
    repeat (12) @(negedge core_clk);
    `CHECK(word_valid, 1'b0)
    `CHECK(busy, 1'b1)
    `CHECK(link.port_a_oe, 1'b0)
    rst = 1'b0;
    settle();
    `CHECK(link.port_swap_select, 1'b1)
    `CHECK(link.port_a_data, sample_a)
    `CHECK(link.port_b_data, sample_b)
    duty(15);
    words(6, 1'b0);
    twos = 1'b1;
    settle();
    `CHECK(link.port_b_data, sample_b ^ dual_conv_pkg::MSB_FLIP)
    words(4, 1'b0);
    mux_mode = 1'b1;
    settle();
    `CHECK(link.port_b_output_disable_n, 1'b1)
    words(8, 1'b1);
    mux_port_b = 1'b1;
    settle();
    `CHECK(link.port_a_output_disable_n, 1'b1)
    words(8, 1'b1);
    mux_mode = 1'b0;
    mux_port_b = 1'b0;
    settle();
    // Receiver stall: the waiting word stands unchanged
    word_ready = 1'b0;
    repeat (40) @(negedge core_clk);
    held = word_data;
    `CHECK(word_valid, 1'b1)
    repeat (20) @(negedge core_clk);
    `CHECK(word_data, held)
    word_ready = 1'b1;
    words(4, 1'b0);
    // Rate change under the stabiliser marks data untrusted
    stab_en = 1'b1;
    settle();
    clk_div = 8'h06;
    repeat (4) @(negedge core_clk);
    `CHECK(busy, 1'b1)
    settle();
    duty(30);
    pd_req_a = 1'b1;
    repeat (20) @(negedge core_clk);
    `CHECK(link.chan_a_powerdown, 1'b1)
    `CHECK(link.chan_b_powerdown, 1'b0)
    `CHECK(refs_up, 1'b1)
    pd_req_b = 1'b1;
    repeat (20) @(negedge core_clk);
    `CHECK(refs_up, 1'b0)
    pd_req_a = 1'b0;
    pd_req_b = 1'b0;
    repeat (20) @(negedge core_clk);
    `CHECK(busy, 1'b1)
    settle();
    `CHECK(refs_up, 1'b1)
    words(4, 1'b0);
    end_of_test();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge core_clk);
    errors++;
    end_of_test();
  end
endmodule : dual_adc_output_and_power_control_bench
`default_nettype wire
